// File: design/power_state_pkg.sv
package power_state_pkg;
   // ****************************************
   // serial bus framing and register map
   // ****************************************
   localparam logic [7:0] REG_SLEEP_EXIT_LATENCY = 8'h2b;
   localparam logic [7:0] REG_EFFICIENCY_HINT    = 8'h30;
   localparam logic [4:0] FRAME_LAST  = 5'h10;   // 17 bits: addr4, cmd5, payload8
   localparam logic [4:0] REPLY_LOAD  = 5'h14;
   localparam logic [4:0] REPLY_DONE  = 5'h1e;
   localparam logic [4:0] BIT_CNT_MAX = 5'h1f;
   localparam logic [4:0] CMD_SET_VID  = 5'h01;
   localparam logic [4:0] CMD_SET_PS   = 5'h02;
   localparam logic [4:0] CMD_SET_HINT = 5'h03;
   localparam logic [4:0] CMD_GET_REG  = 5'h07;
   localparam logic [1:0] ACK_NONE = 2'h0;
   localparam logic [1:0] ACK_OK   = 2'h1;
   localparam logic [1:0] ACK_REJ  = 2'h2;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS      = 8;
   localparam int ON_STEP_NS  = 40;
   localparam int ON_STEP_CYC = (ON_STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int OFF_STEP_NS = 60;
   localparam int FILTER_US   = 10;
   localparam int FILTER_CYC  = FILTER_US * 1000 / CLK_NS;
   // ****************************************
   // current and voltage scaling
   // ****************************************
   localparam int         STEP_AMPS   = 2;
   localparam logic [8:0] HYST_AMPS   = 9'h004;
   localparam int         ERR_STEP_MV = 3;
   localparam logic [7:0] SAT_NORMAL  = 8'h3e;
   localparam logic [7:0] SAT_DOUBLER = 8'h7c;
   localparam logic [7:0] SKEW_START0 = 8'h08;
   localparam logic [7:0] SKEW_START1 = 8'h0c;
   localparam logic [7:0] SKEW_START2 = 8'h10;
   localparam logic [8:0] PERIOD_NOM  = 9'h080;
   localparam logic [8:0] PERIOD_MIN  = 9'h040;
   localparam logic [8:0] PERIOD_MAX  = 9'h0ff;
   // ****************************************
   // fault vector positions
   // ****************************************
   localparam int FLT_STICKY_N = 6;
   localparam int ST_CUR_LIMIT = 8;
   localparam int ST_FSW_HIGH  = 9;
   // power states, gray along the shedding path
   typedef enum logic [2:0] {
      PS0 = 3'h0,
      PS1 = 3'h1,
      PS2 = 3'h3,
      PS3 = 3'h2,
      PS4 = 3'h6
   } pstate_t;
endpackage

// File: design/power_state_phase_manager.sv
`timescale 1ns/1ps
module power_state_phase_manager
   import power_state_pkg::*;
#(
   parameter logic [3:0] BUS_ADDR       = 4'h0,
   parameter logic [7:0] EXIT_LATENCY   = 8'h11   // arbitrary encoded latency
)(
   // clocks and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       svidClock,
   // serial voltage-id bus
   input  wire logic       svidFrame,
   input  wire logic       svidDataIn,
   output logic            svidDataOut,
   output logic            svidDataOe,
   // management bus requests
   input  wire logic       mgmtPsValid,
   input  wire logic [2:0] mgmtPsCode,
   input  wire logic       mgmtStickyClear,
   // analog status pins
   input  wire logic       otpIn,
   input  wire logic       ocpIn,
   input  wire logic       ovpIn,
   input  wire logic       uvpIn,
   input  wire logic       vinUvloIn,
   input  wire logic       vccUvloIn,
   input  wire logic       phaseFaultIn,
   input  wire logic       slowOcpIn,
   input  wire logic       currentLimitIn,
   input  wire logic       fswHighIn,
   // measurements from the sense logic
   input  wire logic [7:0] loadCurrent,
   input  wire logic [7:0] singlePhaseCurrent,
   input  wire logic [7:0] phaseCurrent,
   input  wire logic [7:0] errorMagnitude,
   input  wire logic [8:0] zeroCrossCycles,
   // stored configuration
   input  wire logic       autoMode,
   input  wire logic       phaseCountControl,
   input  wire logic       ps1TwoPhase,
   input  wire logic       autoPassive,
   input  wire logic       wakeOnClock,
   input  wire logic       sleepRampSelect,
   input  wire logic       senseAmpOffEnable,
   input  wire logic       skewEnable,
   input  wire logic       skewHalf,
   input  wire logic [1:0] skewStartSel,
   input  wire logic       doublerMode,
   input  wire logic [2:0] maxPhases,
   input  wire logic [4:0] firstAddThreshold,
   input  wire logic [4:0] thirdPhaseIncrement,
   input  wire logic [4:0] fourthPhaseIncrement,
   input  wire logic [4:0] fifthPhaseIncrement,
   input  wire logic [4:0] sixthPhaseIncrement,
   input  wire logic [7:0] lightLoadEntryLevel,
   input  wire logic [4:0] pulseStartErrorLevel,
   input  wire logic [5:0] onPulseLength,
   input  wire logic [3:0] offTimeAdjust,
   input  wire logic [7:0] largeStepLevel,
   input  wire logic [7:0] oscillationLevel,
   // regulator control outputs
   output logic [2:0]      powerState,
   output logic [2:0]      phaseCount,
   output logic            pwmTristate,
   output logic            rampToZero,
   output logic            senseAmpOff,
   output logic            highSideOn,
   output logic            lowSideOn,
   output logic [7:0]      periodScale,
   output logic            balanceEnable,
   output logic            currentLimitEnable,
   output logic [7:0]      vidCode,
   output logic [7:0]      faultLive,
   output logic [5:0]      faultSticky
);
   function automatic pstate_t psOf(input logic [2:0] n);
      case (n)
         3'h0:    psOf = PS0;
         3'h1:    psOf = PS1;
         3'h2:    psOf = PS2;
         3'h3:    psOf = PS3;
         default: psOf = PS4;
      endcase
   endfunction

   // floor of the low-side trim in clock cycles
   function automatic logic [8:0] trimCycles(input logic [3:0] n);
      trimCycles = 9'((int'(n) * OFF_STEP_NS) / CLK_NS);
   endfunction

   // ****************************************
   // link side, on the bus clock
   // ****************************************
   logic        svidRstM_r, svidRstOk_r;
   logic [4:0]  bitCnt_r, bitCnt_nxt;
   logic [16:0] shift_r, shift_nxt, word_r, word_nxt;
   logic [9:0]  reply_r, reply_nxt;
   logic        frameTgl_r, frameTgl_nxt, edgeTgl_r, edgeTgl_nxt;
   logic        dataOut_nxt, dataOe_nxt;
   logic [9:0]  replyWord_r, replyWord_nxt;

   // frame shifter; edge toggle feeds the wake-on-clock detector
   always_comb
   begin
      bitCnt_nxt   = bitCnt_r;
      shift_nxt    = shift_r;
      word_nxt     = word_r;
      frameTgl_nxt = frameTgl_r;
      reply_nxt    = reply_r;
      dataOut_nxt  = svidDataOut;
      dataOe_nxt   = 1'b0;
      edgeTgl_nxt  = ~edgeTgl_r;
      if (!svidRstOk_r)
      begin
         bitCnt_nxt   = '0;
         shift_nxt    = '0;
         word_nxt     = '0;
         frameTgl_nxt = 1'b0;
         reply_nxt    = '0;
         dataOut_nxt  = 1'b0;
         edgeTgl_nxt  = 1'b0;
      end
      else if (!svidFrame)
         bitCnt_nxt = '0;
      else
      begin
         if (bitCnt_r != BIT_CNT_MAX)
            bitCnt_nxt = bitCnt_r + 5'h01;
         if (bitCnt_r <= FRAME_LAST)
            shift_nxt = {shift_r[15:0], svidDataIn};
         if (bitCnt_r == FRAME_LAST)
         begin
            word_nxt     = {shift_r[15:0], svidDataIn};
            frameTgl_nxt = ~frameTgl_r;
         end
         // reply word is quasi-static by now: the core settled it long before
         if (bitCnt_r == REPLY_LOAD)
         begin
            reply_nxt   = replyWord_r;
            dataOut_nxt = replyWord_r[9];
            dataOe_nxt  = 1'b1;
         end
         else if (bitCnt_r > REPLY_LOAD && bitCnt_r < REPLY_DONE)
         begin
            reply_nxt   = {reply_r[8:0], 1'b0};
            dataOut_nxt = reply_r[8];
            dataOe_nxt  = 1'b1;
         end
      end
   end

   always_ff @(posedge svidClock)
   begin
      svidRstM_r  <= reset_n;
      svidRstOk_r <= svidRstM_r;
      bitCnt_r    <= bitCnt_nxt;
      shift_r     <= shift_nxt;
      word_r      <= word_nxt;
      frameTgl_r  <= frameTgl_nxt;
      edgeTgl_r   <= edgeTgl_nxt;
      reply_r     <= reply_nxt;
      svidDataOut <= dataOut_nxt;
      svidDataOe  <= dataOe_nxt;
   end

   // ****************************************
   // crossings into the core clock
   // ****************************************
   logic       frameM_r, frameS_r, frameP_r, edgeM_r, edgeS_r, edgeP_r;
   logic [9:0] statusM_r, status_r;
   logic       newFrame, clockSeen;

   always_ff @(posedge clock)
   begin
      frameM_r  <= frameTgl_r;
      frameS_r  <= frameM_r;
      frameP_r  <= frameS_r;
      edgeM_r   <= edgeTgl_r;
      edgeS_r   <= edgeM_r;
      edgeP_r   <= edgeS_r;
      statusM_r <= {fswHighIn, currentLimitIn, slowOcpIn, phaseFaultIn,
                    vccUvloIn, vinUvloIn, uvpIn, ovpIn, ocpIn, otpIn};
      status_r  <= statusM_r;
   end

   assign newFrame  = reset_n & (frameS_r ^ frameP_r);
   assign clockSeen = reset_n & (edgeS_r ^ edgeP_r);

   // ****************************************
   // command decode and replies
   // ****************************************
   logic       addrOk, cmdSetVid, cmdSetPs, cmdHint, cmdGet, mgmtPs;
   logic [4:0] cmd;
   logic [7:0] pay;
   logic [7:0] hint_r, hint_nxt, vid_nxt;

   assign addrOk    = newFrame && (word_r[16:13] == BUS_ADDR);
   assign cmd       = word_r[12:8];
   assign pay       = word_r[7:0];
   assign cmdSetVid = addrOk && (cmd == CMD_SET_VID);
   assign cmdSetPs  = addrOk && (cmd == CMD_SET_PS) && (pay <= 8'h04);
   assign cmdHint   = addrOk && (cmd == CMD_SET_HINT);
   assign cmdGet    = addrOk && (cmd == CMD_GET_REG);
   assign mgmtPs    = mgmtPsValid && (mgmtPsCode < 3'h4);

   always_comb
   begin
      replyWord_nxt = replyWord_r;
      hint_nxt      = hint_r;
      vid_nxt       = vidCode;
      if (newFrame && !addrOk)
         replyWord_nxt = {ACK_NONE, 8'h00};
      else if (cmdSetVid)
      begin
         vid_nxt       = pay;
         replyWord_nxt = {ACK_OK, 8'h00};
      end
      else if (cmdSetPs)
         replyWord_nxt = {ACK_OK, 8'h00};
      else if (cmdHint)
      begin
         hint_nxt      = pay;
         replyWord_nxt = {ACK_OK, 8'h00};
      end
      else if (cmdGet && pay == REG_SLEEP_EXIT_LATENCY)
         replyWord_nxt = {ACK_OK, EXIT_LATENCY};
      else if (cmdGet && pay == REG_EFFICIENCY_HINT)
         replyWord_nxt = {ACK_OK, hint_r};
      else if (addrOk)
         replyWord_nxt = {ACK_REJ, 8'h00};
      if (!reset_n)
      begin
         replyWord_nxt = '0;
         hint_nxt      = '0;
         vid_nxt       = '0;
      end
   end

   always_ff @(posedge clock)
   begin
      replyWord_r <= replyWord_nxt;
      hint_r      <= hint_nxt;
      vidCode     <= vid_nxt;
   end

   // ****************************************
   // power state machine
   // ****************************************
   pstate_t state_r, state_nxt;
   logic    curLimit, fswHigh, deState;

   assign curLimit = status_r[ST_CUR_LIMIT];
   assign fswHigh  = status_r[ST_FSW_HIGH];
   assign deState  = (state_r == PS2) || (state_r == PS3);

   // serial state commands first, then forced exits, then management requests, then autonomous moves
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         PS4:
            if (wakeOnClock ? clockSeen : (cmdSetVid || (cmdSetPs && pay[2:0] != 3'h4)))
               state_nxt = cmdSetPs ? psOf(pay[2:0]) : PS0;
         PS0, PS1, PS2, PS3:
            if (cmdSetPs)
               state_nxt = psOf(pay[2:0]);
            else if (state_r != PS0 && (curLimit || cmdSetVid))
               state_nxt = PS0;
            else if (mgmtPs)
               state_nxt = psOf(mgmtPsCode);
            else if (autoMode && deState && fswHigh)
               state_nxt = PS0;
            else if (autoMode && state_r == PS0 && phaseCount == 3'h1 && !curLimit
                     && singlePhaseCurrent < lightLoadEntryLevel)
               state_nxt = autoPassive ? PS3 : PS2;
         default:
            state_nxt = PS0;
      endcase
      if (!reset_n)
         state_nxt = PS0;
   end

   always_ff @(posedge clock)
   begin
      state_r            <= state_nxt;
      powerState         <= state_nxt;
      pwmTristate        <= (state_nxt == PS4);
      rampToZero         <= (state_nxt == PS4) && sleepRampSelect;
      senseAmpOff        <= (state_nxt == PS3) && senseAmpOffEnable;
      balanceEnable      <= (state_nxt != PS4);
      currentLimitEnable <= (state_nxt != PS4);
   end

   // ****************************************
   // phase adding and shedding
   // ****************************************
   logic [8:0]  addPt [1:5];
   logic [4:0]  incr  [2:5];
   logic [2:0]  phase_nxt;
   logic [10:0] hold_r, hold_nxt;
   logic        largeStep, oscillating;

   assign incr[2]     = thirdPhaseIncrement;
   assign incr[3]     = fourthPhaseIncrement;
   assign incr[4]     = fifthPhaseIncrement;
   assign incr[5]     = sixthPhaseIncrement;
   assign addPt[1]    = 9'(int'(firstAddThreshold) * STEP_AMPS);
   assign largeStep   = errorMagnitude > largeStepLevel;
   assign oscillating = errorMagnitude > oscillationLevel;

   // cumulative add points, one per extra phase
   generate
      for (genvar k = 2; k <= 5; k++)
      begin : g_add
         assign addPt[k] = addPt[k-1] + 9'(int'(incr[k]) * STEP_AMPS);
      end
   endgenerate

   always_comb
   begin
      phase_nxt = phaseCount;
      hold_nxt  = hold_r;
      case (state_r)
         PS0:
            if (!phaseCountControl)
               phase_nxt = maxPhases;
            else if (largeStep)
            begin
               phase_nxt = maxPhases;
               hold_nxt  = 11'(FILTER_CYC);
            end
            else if (hold_r != '0)
               hold_nxt = hold_r - 11'h001;
            else if (phaseCount < maxPhases && phaseCount != 3'h0 && phaseCount < 3'h6
                     && {1'b0, loadCurrent} > addPt[phaseCount])
               phase_nxt = phaseCount + 3'h1;
            else if (phaseCount > 3'h1 && phaseCount <= 3'h6 && !oscillating
                     && {1'b0, loadCurrent} + HYST_AMPS < addPt[phaseCount - 3'h1])
               phase_nxt = phaseCount - 3'h1;
            else if (phaseCount == 3'h0 || phaseCount > maxPhases)
               phase_nxt = maxPhases;
         PS1:
            phase_nxt = ps1TwoPhase ? 3'h2 : 3'h1;
         PS2, PS3:
            phase_nxt = 3'h1;
         PS4:
            phase_nxt = 3'h0;
         default:
            phase_nxt = 3'h1;
      endcase
      // near-off entry drops the phase count in the same cycle that tristates the pwm
      if (state_nxt == PS4)
         phase_nxt = 3'h0;
      if (!reset_n)
      begin
         phase_nxt = 3'h1;
         hold_nxt  = '0;
      end
   end

   always_ff @(posedge clock)
   begin
      phaseCount <= phase_nxt;
      hold_r     <= hold_nxt;
   end

   // ****************************************
   // switching period skew on loop one
   // ****************************************
   logic [7:0] satCur, skewStart;
   logic [8:0] excess, period_nxt;

   // one period code per ampere beyond the start point
   always_comb
   begin
      satCur = phaseCurrent;
      if (satCur > (doublerMode ? SAT_DOUBLER : SAT_NORMAL))
         satCur = doublerMode ? SAT_DOUBLER : SAT_NORMAL;
      case (skewStartSel)
         2'h0:    skewStart = SKEW_START0;
         2'h1:    skewStart = SKEW_START1;
         default: skewStart = SKEW_START2;
      endcase
      excess = (satCur > skewStart) ? {1'b0, satCur - skewStart} : 9'h000;
      if (!skewEnable || !reset_n)
         period_nxt = PERIOD_NOM;
      else if (skewHalf)
         period_nxt = (PERIOD_NOM + excess > PERIOD_MAX) ? PERIOD_MAX : PERIOD_NOM + excess;
      else
         period_nxt = (excess > PERIOD_NOM - PERIOD_MIN) ? PERIOD_MIN : PERIOD_NOM - excess;
   end

   always_ff @(posedge clock)
      periodScale <= period_nxt[7:0];

   // ****************************************
   // constant on-time pulses in discontinuous states
   // ****************************************
   logic [8:0] pulse_r, pulse_nxt, low_r, low_nxt, highRun_r, highRun_nxt;
   logic       deNext;

   // pulses stop in the cycle the state leaves, so no live pulse overlaps tristate
   assign deNext = (state_nxt == PS2) || (state_nxt == PS3);

   // the same engine serves both discontinuous states
   always_comb
   begin
      pulse_nxt   = '0;
      low_nxt     = '0;
      highRun_nxt = highSideOn ? highRun_r + 9'h001 : 9'h000;
      if (!reset_n)
         highRun_nxt = '0;
      else if (!deNext)
         ;
      else if (pulse_r != '0)
      begin
         pulse_nxt = pulse_r - 9'h001;
         if (pulse_r == 9'h001)
            low_nxt = (zeroCrossCycles > trimCycles(offTimeAdjust)) ?
                      zeroCrossCycles - trimCycles(offTimeAdjust) : 9'h000;
      end
      else if (low_r != '0)
         low_nxt = low_r - 9'h001;
      else if ({1'b0, errorMagnitude} > 9'(int'(pulseStartErrorLevel) * ERR_STEP_MV))
         pulse_nxt = 9'(int'(onPulseLength) * ON_STEP_CYC);
   end

   always_ff @(posedge clock)
   begin
      pulse_r    <= pulse_nxt;
      low_r      <= low_nxt;
      highRun_r  <= highRun_nxt;
      highSideOn <= (pulse_nxt != '0);
      lowSideOn  <= (low_nxt != '0);
   end

   // ****************************************
   // fault flags
   // ****************************************
   logic [5:0] sticky_nxt;

   // a fault present in the clearing cycle survives the clear
   always_comb
   begin
      sticky_nxt = (faultSticky & {FLT_STICKY_N{~mgmtStickyClear}})
                   | status_r[FLT_STICKY_N-1:0];
      if (!reset_n)
         sticky_nxt = '0;
   end

   always_ff @(posedge clock)
   begin
      faultSticky <= sticky_nxt;
      faultLive   <= reset_n ? status_r[7:0] : 8'h00;
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_sleep_by_serial_vid_bus:  assert property ($rose(pwmTristate) |-> $past(cmdSetPs) && $past(pay[2:0]) == 3'h4)
      else $error("near-off entered without serial command");
   a_sleep_pwm_off:  assert property (pwmTristate |-> phaseCount == 3'h0 && !highSideOn && !balanceEnable)
      else $error("pwm active in near-off");
   a_limit_exit:     assert property (curLimit && deState && !cmdSetPs |=> state_r == PS0)
      else $error("current limit did not force full power");
   a_light_cmd_only: assert property ($rose(state_r == PS1) |-> $past(cmdSetPs) || $past(mgmtPs))
      else $error("light-load state entered without command");
   a_step_max:       assert property (state_r == PS0 && phaseCountControl && largeStep |=> phaseCount == maxPhases)
      else $error("large step did not raise phases");
   a_step_hold:      assert property (state_r == PS0 && largeStep ##1 state_r == PS0 |=>
                                      $stable(phaseCount) || state_r != PS0 || largeStep)
      else $error("phases changed inside filter hold");
   a_pulse_width:    assert property ($fell(highSideOn) && $past(deState) && deState |->
                                      $past(highRun_r) + 9'h001 == 9'(int'(onPulseLength) * ON_STEP_CYC))
      else $error("on pulse length wrong");
   a_sticky_set:     assert property (status_r[0] |=> faultSticky[0])
      else $error("sticky over-temperature lost");
   a_sticky_keep:    assert property (faultSticky[1] && !mgmtStickyClear |=> faultSticky[1])
      else $error("sticky flag cleared without command");
   a_sense_off:      assert property (senseAmpOff |-> state_r == PS3)
      else $error("sense amplifiers off outside passive state");

   c_sleep_wake:  cover property (pwmTristate ##[1:1000] !pwmTristate);
   c_auto_de:     cover property (state_r == PS0 ##1 state_r == PS2);
   c_phase_shed:  cover property (phaseCount == 3'h3 ##1 phaseCount == 3'h2);
   c_pulse:       cover property ($rose(highSideOn) ##[1:100] $rose(lowSideOn));
endmodule

// File: verif/serial_vid_bus_master.sv
`timescale 1ns/1ps
module serial_vid_bus_master (
   // serial voltage-id bus, master side
   output logic     svidClock,
   output logic     svidFrame,
   output logic     svidDataIn,
   input wire logic svidDataOut,
   input wire logic svidDataOe
);
   // ****************************************
   // clock parks low outside frames
   // ****************************************
   initial
   begin
      {svidClock, svidFrame, svidDataIn} = 3'h0;
   end
   // idle edges flip data so no stale level is trusted
   task automatic toggle(input int n);
      repeat (n)
      begin
         svidDataIn = ~svidDataIn;
         #15 svidClock = 1'b1;
         #15 svidClock = 1'b0;
      end
   endtask
   // near-off is only ever asked for through this frame
   task automatic xfer(input logic [16:0] w, output logic [9:0] r);
      svidFrame = 1'b1;
      for (int k = 1; k <= 31; k++)
      begin
         svidDataIn = (k <= 17) ? w[17-k] : ~svidDataIn;
         #15 svidClock = 1'b1;
         #15 svidClock = 1'b0;
         // a bit seen while output enable is low reads unknown and fails the compare
         if (k > 20 && k < 31)
            r[30-k] = svidDataOe ? svidDataOut : 1'bx;
      end
      // one edge with the frame low rearms the bit counter for the next frame
      svidFrame = 1'b0;
      #15 svidClock = 1'b1;
      #15 svidClock = 1'b0;
   endtask
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
   import power_state_pkg::*;
   localparam logic [7:0] LAT = 8'h5a;
   logic clock, reset_n, svidClock, svidFrame, svidDataIn, svidDataOut, svidDataOe, mgmtPsValid, mgmtStickyClear;
   logic otpIn, ocpIn, ovpIn, uvpIn, vinUvloIn, vccUvloIn, phaseFaultIn, slowOcpIn, currentLimitIn, fswHighIn;
   logic autoMode, phaseCountControl, ps1TwoPhase, autoPassive, wakeOnClock, sleepRampSelect, senseAmpOffEnable;
   logic skewEnable, skewHalf, doublerMode, pwmTristate, rampToZero, senseAmpOff, highSideOn, lowSideOn;
   logic balanceEnable, currentLimitEnable;
   logic [1:0] skewStartSel;
   logic [2:0] mgmtPsCode, maxPhases, powerState, phaseCount;
   logic [3:0] offTimeAdjust;
   logic [4:0] firstAddThreshold, thirdPhaseIncrement, fourthPhaseIncrement, fifthPhaseIncrement;
   logic [4:0] sixthPhaseIncrement, pulseStartErrorLevel;
   logic [5:0] onPulseLength, faultSticky;
   logic [7:0] loadCurrent, singlePhaseCurrent, phaseCurrent, errorMagnitude, lightLoadEntryLevel, largeStepLevel;
   logic [7:0] oscillationLevel, periodScale, vidCode, faultLive, val;
   logic [8:0] zeroCrossCycles;
   logic [9:0] rep, obsV, expQ[$];
   int mismatches, total_checks;
   event got;
   power_state_phase_manager #(.EXIT_LATENCY(LAT)) DUT (.*);
   serial_vid_bus_master svm (.*);
   // ****************************************
   // checking and closing
   // ****************************************
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (mismatches == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // the watcher pairs each result with the oldest note
   always @(got) check(obsV, expQ.pop_front());
   task automatic note(input logic [9:0] obs, input logic [9:0] exp);
      expQ.push_back(exp);
      obsV = obs;
      ->got;
      #1;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic cmd(input logic [4:0] c, input logic [7:0] p, input logic [1:0] ack);
      svm.xfer({4'h0, c, p}, rep);
      note(10'(rep[9:8]), 10'(ack));
   endtask
   task automatic mgmt(input logic [2:0] c);
      @(posedge clock);
      mgmtPsValid <= 1'b1;
      mgmtPsCode <= c;
      @(posedge clock);
      mgmtPsValid <= 1'b0;
      cyc(3);
   endtask
   // ****************************************
   // clock, watchdog, scenarios
   // ****************************************
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // whole run is some 18 us; over ten times that means a hang
   initial
   begin
      #200000;
      mismatches++;
      complete_run();
   end
   initial
   begin
      void'($urandom(11));
      {reset_n, mgmtPsValid, mgmtStickyClear, otpIn, ocpIn, ovpIn, uvpIn, vinUvloIn, vccUvloIn, phaseFaultIn,
       slowOcpIn, currentLimitIn, fswHighIn, autoMode, phaseCountControl, ps1TwoPhase, autoPassive, wakeOnClock,
       senseAmpOffEnable, skewEnable, skewHalf, doublerMode, skewStartSel, mgmtPsCode, loadCurrent, errorMagnitude,
       phaseCurrent, zeroCrossCycles, offTimeAdjust} = '0;
      {maxPhases, firstAddThreshold, lightLoadEntryLevel, singlePhaseCurrent} = {3'h6, 5'h05, 8'h0a, 8'h02};
      {thirdPhaseIncrement, fourthPhaseIncrement, fifthPhaseIncrement, sixthPhaseIncrement} = {4{5'h03}};
      {pulseStartErrorLevel, onPulseLength, largeStepLevel, oscillationLevel} = {5'h04, 6'h02, 8'h40, 8'h20};
      sleepRampSelect = 1'($urandom);
      svm.toggle(4);
      @(posedge clock) reset_n <= 1'b1;
      svm.toggle(4);
      note(10'({powerState, periodScale}), 10'({PS0, PERIOD_NOM[7:0]}));
      cmd(CMD_GET_REG, REG_SLEEP_EXIT_LATENCY, ACK_OK);
      note(10'(rep[7:0]), 10'(LAT));
      val = 8'($urandom);
      cmd(CMD_SET_HINT, val, ACK_OK);
      cmd(CMD_GET_REG, REG_EFFICIENCY_HINT, ACK_OK);
      note(10'(rep[7:0]), 10'(val));
      note(10'(phaseCount), 10'(maxPhases));
      cmd(5'h1f, 8'h00, ACK_REJ);
      cmd(CMD_SET_PS, 8'h05, ACK_REJ);
      cmd(CMD_SET_PS, 8'h04, ACK_OK);
      cyc(6);
      note(10'({powerState, pwmTristate, rampToZero}), 10'({PS4, 1'b1, sleepRampSelect}));
      mgmt(3'h0);
      note(10'(powerState), 10'(PS4));
      @(posedge clock) {wakeOnClock, senseAmpOffEnable} <= 2'h3;
      svm.toggle(2);
      cyc(8);
      note(10'({powerState, pwmTristate}), 10'({PS0, 1'b0}));
      mgmt(3'h3);
      note(10'({powerState, senseAmpOff}), 10'({PS3, 1'b1}));
      @(posedge clock) {errorMagnitude, zeroCrossCycles} <= {8'h10, 9'h00c};
      cyc(3);
      note(10'({highSideOn, lowSideOn}), 10'h002);
      cyc(10);
      note(10'({highSideOn, lowSideOn}), 10'h001);
      val = 8'($urandom);
      cmd(CMD_SET_VID, val, ACK_OK);
      cyc(6);
      note(10'({powerState, vidCode}), 10'({PS0, val}));
      @(posedge clock) {phaseCountControl, autoMode} <= 2'h3;
      cyc(1300);
      note(10'({powerState, phaseCount}), 10'({PS2, 3'h1}));
      @(posedge clock) currentLimitIn <= 1'b1;
      cyc(6);
      note(10'({powerState, currentLimitEnable}), 10'({PS0, 1'b1}));
      @(posedge clock) {autoMode, currentLimitIn, errorMagnitude} <= {2'h0, 8'hff};
      cyc(3);
      @(posedge clock) errorMagnitude <= 8'h00;
      cyc(20);
      note(10'({phaseCount, balanceEnable}), 10'({maxPhases, 1'b1}));
      @(posedge clock) {skewEnable, phaseCurrent} <= {1'b1, 8'hc8};
      cyc(4);
      note(10'(periodScale), 10'(8'h4a));
      @(posedge clock) {skewHalf, doublerMode, skewStartSel} <= 4'he;
      cyc(4);
      note(10'(periodScale), 10'(8'hec));
      @(posedge clock) {otpIn, phaseFaultIn} <= 2'h3;
      cyc(5);
      @(posedge clock) otpIn <= 1'b0;
      cyc(5);
      note(10'({faultSticky, faultLive[6]}), 10'({6'h01, 1'b1}));
      @(posedge clock) {mgmtStickyClear, phaseFaultIn} <= 2'h2;
      cyc(5);
      note(10'(faultSticky), 10'h000);
      note(10'(faultLive), 10'h000);
      complete_run();
   end
endmodule
